// ---- logic/usm_pkg.sv ----
// Package of the serial port control block running as a shift-clock master:
// register indices, field positions, reset values and shared types.
// Assumes the APB word address is the register index times four.
package usm_pkg;

  localparam int ADDR_W = 12;
  localparam int BAUD_W = 12;

  // Register indices; byte address is index * 4
  localparam logic [9:0] IDX_STATUS = 10'h0c0;
  localparam logic [9:0] IDX_CTRL = 10'h0c1;
  localparam logic [9:0] IDX_FMT = 10'h0c2;
  localparam logic [9:0] IDX_BAUD = 10'h0c4;
  localparam logic [9:0] IDX_DATA = 10'h0c6;
  localparam logic [9:0] IDX_EVT = 10'h0c8;
  localparam logic [9:0] IDX_MASK = 10'h0c9;
  localparam logic [9:0] IDX_GIE = 10'h0ca;

  // Status bit positions
  localparam int STA_RXC = 7;
  localparam int STA_TXC = 6;
  localparam int STA_TX_BUFFER_EMPTY_FLAG = 5;

  // Event, mask and enable vectors share this layout
  localparam int EVT_RX = 2;
  localparam int EVT_TX = 1;
  localparam int EVT_TX_BUFFER_EMPTY_FLAG = 0;

  // Reset values and constant read-back of reserved fields
  localparam logic [7:0] FMT_RESET = 8'h06;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [2:0] CTRL_RSVD_READ = 3'h6;
  localparam logic [4:0] STATUS_RSVD_READ = 5'h06;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h000;
  localparam logic [2:0] MASK_RESET = 3'h7;

  // Sixteen shift-clock edges make one eight-bit frame
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam int RX_DEPTH = 2;

  typedef enum logic [1:0] {
    MODE_ASYNC = 2'h0,
    MODE_SYNC = 2'h1,
    MODE_RSVD = 2'h2,
    MODE_MSPI = 2'h3
  } usm_mode_type;

  typedef struct packed {
    logic rx_irq_enable;
    logic tx_done_irq_enable;
    logic buffer_empty_irq_enable;
    logic receiver_enable;
    logic transmitter_enable;
  } usm_ctrl_type;

  typedef struct packed {
    usm_mode_type port_mode_select;
    logic [2:0] rsvd;
    logic bit_order_select;
    logic shift_clock_phase;
    logic shift_clock_polarity;
  } usm_fmt_type;

endpackage

// ---- logic/usm_rx_fifo.sv ----
// Receive buffer: small FIFO whose head word comes out of a register.
// Assumes DEPTH is a power of two; a push into a full buffer is dropped.
`timescale 1ns/1ns
module usm_rx_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic pop_i,
  output logic [W-1:0] rdata_o,
  output logic empty_o,
  output logic full_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic [W-1:0] head_reg;
  logic do_push;
  logic do_pop;

  assign empty_o = (count_reg == '0);
  assign full_o = (count_reg == (PW+1)'(DEPTH));
  // Newest word is lost on overflow, older words stay intact
  assign do_push = push_i & ~full_o;
  assign do_pop = pop_i & ~empty_o;
  assign rdata_o = head_reg;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(do_push);
      rd_ptr_reg <= rd_ptr_reg + PW'(do_pop);
      count_reg <= count_reg + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      head_reg <= '0;
    end else if (flush_i) begin
      head_reg <= '0;
    end else if (do_pop && count_reg > 1) begin
      head_reg <= mem_reg[rd_ptr_reg + 1'b1];
    end else if (do_push && (empty_o || do_pop)) begin
      head_reg <= wdata_i;
    end
  end

endmodule

// ---- logic/usm_spi_ctrl.sv ----
// Serial port control block in shift-clock master mode, with an APB slave.
// Assumes a 100 MHz clk_i; the serial input pin is asynchronous to it.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns

// Notes on behaviour
// - Transmit-complete interrupt needs its enable, global enable and the done flag.
// - Buffer-empty interrupt needs its enable, global enable and the empty flag.
// - Receiver enable turns receiver on and claims the serial input pin.
// - Clearing receiver enable throws away everything in the receive buffer.
// - Transmitter enable turns transmitter on and claims the serial output pin.
// - After disable, transmitter finishes shift register and buffer, then frees pin.
// - Mode field: 00 async, 01 sync, 11 master shift, 10 reserved.
// - Order, phase and polarity are taken in the write that picks master mode.
// - Bit order one sends least significant bit first, zero sends most first.
// - Clock phase picks sampling on first or last shift-clock edge.
// - Clock polarity sets idle shift-clock level; with phase it fixes timing.
// - Each accepted data write (transmitter enabled, buffer free) queues a frame that sends and receives one byte.
// - Done flag sets when frame leaves and buffer empty; clears on ack or one.
// - Polarity and phase behave as a standard shift-clock master.
module usm_spi_ctrl
  import usm_pkg::*;
#(
  parameter int RX_BUF_DEPTH = RX_DEPTH
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  input wire logic irq_ack_i,
  input wire logic rxd_i,
  output logic rx_pin_owned_o,
  input wire logic port_txd_i,
  input wire logic port_txd_oe_i,
  output logic txd_o,
  output logic txd_oe_o,
  output logic xck_o,
  output logic xck_oe_o
);

  typedef enum logic {ST_IDLE, ST_RUN} usm_state_type;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
    hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  function automatic logic out_bit(input logic [7:0] b, input logic lsb_first);
    out_bit = lsb_first ? b[0] : b[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] b, input logic in, input logic lsb_first);
    shift_in = lsb_first ? {in, b[7:1]} : {b[6:0], in};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and their wires

  usm_ctrl_type ctrl_reg;
  usm_fmt_type fmt_reg;
  logic [BAUD_W-1:0] baud_reg;
  logic [2:0] evt_reg;
  logic [2:0] mask_reg;
  logic gie_reg;
  logic tx_done_flag_reg;
  logic tx_buffer_empty_flag_reg;
  logic [7:0] txbuf_reg;
  usm_state_type state_reg;
  logic [3:0] edge_reg;
  logic [BAUD_W-1:0] baud_cnt_reg;
  logic [7:0] processor_status_register_reg;
  logic in_bit_reg;
  logic txd_reg;
  logic sck_reg;
  logic rxd_meta_reg;
  logic rxd_sync_reg;

  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic spi_mode;
  logic tick;
  logic frame_end;
  logic start;
  logic tx_owner;
  logic [7:0] shifted;
  logic [7:0] rx_byte;
  logic rx_done_flag;
  logic [7:0] rx_head;
  logic rx_empty;
  logic rx_pop;
  logic rx_push;
  logic load_pulse;
  logic [2:0] live;
  logic [2:0] enables;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped word

  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;
  assign rd = acc & ~pwrite_i;
  assign mapped = hit(paddr_i, IDX_STATUS) | hit(paddr_i, IDX_CTRL) | hit(paddr_i, IDX_FMT)
                | hit(paddr_i, IDX_BAUD) | hit(paddr_i, IDX_DATA) | hit(paddr_i, IDX_EVT)
                | hit(paddr_i, IDX_MASK) | hit(paddr_i, IDX_GIE);
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;

  always_comb begin
    prdata_o = 32'h0000_0000;
    if (hit(paddr_i, IDX_STATUS)) begin
      prdata_o[7:0] = {rx_done_flag, tx_done_flag_reg, tx_buffer_empty_flag_reg, STATUS_RSVD_READ};
    end else if (hit(paddr_i, IDX_CTRL)) begin
      prdata_o[7:0] = {ctrl_reg, CTRL_RSVD_READ};
    end else if (hit(paddr_i, IDX_FMT)) begin
      prdata_o[7:0] = {fmt_reg.port_mode_select, 3'h0, fmt_reg.bit_order_select,
                       fmt_reg.shift_clock_phase, fmt_reg.shift_clock_polarity};
    end else if (hit(paddr_i, IDX_BAUD)) begin
      prdata_o[BAUD_W-1:0] = baud_reg;
    end else if (hit(paddr_i, IDX_DATA)) begin
      prdata_o[7:0] = rx_head;
    end else if (hit(paddr_i, IDX_EVT)) begin
      prdata_o[2:0] = evt_reg;
    end else if (hit(paddr_i, IDX_MASK)) begin
      prdata_o[2:0] = mask_reg;
    end else if (hit(paddr_i, IDX_GIE)) begin
      prdata_o[0] = gie_reg;
    end
  end

  // Plain configuration; reserved bits are dropped whatever software writes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= CTRL_RESET;
      fmt_reg <= FMT_RESET;
      baud_reg <= BAUD_RESET;
      mask_reg <= MASK_RESET;
      gie_reg <= 1'b0;
    end else if (wr) begin
      if (hit(paddr_i, IDX_CTRL)) begin
        ctrl_reg <= pwdata_i[7:3];
      end
      if (hit(paddr_i, IDX_FMT)) begin
        // Mode, order, phase and polarity land together in one write
        fmt_reg <= {pwdata_i[7:6], 3'h0, pwdata_i[2:0]};
      end
      if (hit(paddr_i, IDX_BAUD)) begin
        baud_reg <= pwdata_i[BAUD_W-1:0];
      end
      if (hit(paddr_i, IDX_MASK)) begin
        mask_reg <= pwdata_i[2:0];
      end
      if (hit(paddr_i, IDX_GIE)) begin
        gie_reg <= pwdata_i[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and its empty flag

  // Only master mode moves frames; other modes hold the buffer
  assign spi_mode = (fmt_reg.port_mode_select == MODE_MSPI);
  // Held by enable, by a frame in flight or by a pending byte
  assign tx_owner = ctrl_reg.transmitter_enable | (state_reg == ST_RUN) | ~tx_buffer_empty_flag_reg;
  assign start = spi_mode & ~tx_buffer_empty_flag_reg & ((state_reg == ST_IDLE) | frame_end);
  assign load_pulse = start;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txbuf_reg <= 8'h00;
      tx_buffer_empty_flag_reg <= 1'b1;
    end else begin
      if (start) begin
        tx_buffer_empty_flag_reg <= 1'b1;
      end
      // A write to the data word queues a frame; a full buffer ignores it
      if (wr && hit(paddr_i, IDX_DATA) && ctrl_reg.transmitter_enable
          && (tx_buffer_empty_flag_reg || start)) begin
        txbuf_reg <= pwdata_i[7:0];
        tx_buffer_empty_flag_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine; half a shift-clock period is baud_reg + 1 cycles

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxd_meta_reg <= 1'b0;
      rxd_sync_reg <= 1'b0;
    end else begin
      rxd_meta_reg <= rxd_i;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  assign tick = (state_reg == ST_RUN) && (baud_cnt_reg == '0);
  assign frame_end = tick && (edge_reg == LAST_EDGE);
  assign shifted = shift_in(processor_status_register_reg, in_bit_reg, fmt_reg.bit_order_select);
  // With late sampling the last bit is taken on the final edge itself
  assign rx_byte = fmt_reg.shift_clock_phase ?
                   shift_in(processor_status_register_reg, rxd_sync_reg, fmt_reg.bit_order_select) : shifted;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_IDLE;
      edge_reg <= 4'h0;
      baud_cnt_reg <= BAUD_RESET;
      processor_status_register_reg <= 8'h00;
      in_bit_reg <= 1'b0;
      txd_reg <= 1'b1;
      sck_reg <= 1'b0;
    end else begin
      if (state_reg == ST_IDLE) begin
        // Idle level of the shift clock follows polarity
        sck_reg <= fmt_reg.shift_clock_polarity;
      end else if (tick) begin
        baud_cnt_reg <= baud_reg;
        sck_reg <= ~sck_reg;
        edge_reg <= edge_reg + 4'h1;
        if (!edge_reg[0]) begin
          if (!fmt_reg.shift_clock_phase) begin
            in_bit_reg <= rxd_sync_reg;
          end else if (edge_reg == 4'h0) begin
            txd_reg <= out_bit(processor_status_register_reg, fmt_reg.bit_order_select);
          end else begin
            processor_status_register_reg <= shifted;
            txd_reg <= out_bit(shifted, fmt_reg.bit_order_select);
          end
        end else begin
          if (fmt_reg.shift_clock_phase) begin
            in_bit_reg <= rxd_sync_reg;
          end else if (edge_reg != LAST_EDGE) begin
            processor_status_register_reg <= shifted;
            txd_reg <= out_bit(shifted, fmt_reg.bit_order_select);
          end
        end
      end else begin
        baud_cnt_reg <= baud_cnt_reg - 1'b1;
      end
      // Next byte goes straight in when a frame ends, so frames abut
      if (start) begin
        state_reg <= ST_RUN;
        edge_reg <= 4'h0;
        baud_cnt_reg <= baud_reg;
        processor_status_register_reg <= txbuf_reg;
        if (!fmt_reg.shift_clock_phase) begin
          txd_reg <= out_bit(txbuf_reg, fmt_reg.bit_order_select);
        end
      end else if (frame_end) begin
        state_reg <= ST_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side

  // Disabling the receiver flushes the buffer, so its done flag drops
  assign rx_push = frame_end & ctrl_reg.receiver_enable;
  assign rx_pop = rd & hit(paddr_i, IDX_DATA) & ~rx_empty;
  assign rx_done_flag = ~rx_empty;

  usm_rx_fifo #(
    .W(8),
    .DEPTH(RX_BUF_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .flush_i(~ctrl_reg.receiver_enable),
    .push_i(rx_push),
    .wdata_i(rx_byte),
    .pop_i(rx_pop),
    .rdata_o(rx_head),
    .empty_o(rx_empty),
    .full_o()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flags, events and interrupt

  // Set wins over an ack or a write-one clear in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_done_flag_reg <= 1'b0;
    end else if (frame_end && !start) begin
      tx_done_flag_reg <= 1'b1;
    end else if (irq_ack_i || (wr && hit(paddr_i, IDX_STATUS) && pwdata_i[STA_TXC])) begin
      tx_done_flag_reg <= 1'b0;
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      evt_reg <= 3'h0;
    end else begin
      if (wr && hit(paddr_i, IDX_EVT)) begin
        evt_reg <= evt_reg & ~pwdata_i[2:0] | {rx_push, frame_end & ~start, load_pulse};
      end else begin
        evt_reg <= evt_reg | {rx_push, frame_end & ~start, load_pulse};
      end
    end
  end

  // Live flags gate the sticky events, so a cleared flag silences its source
  assign live = {rx_done_flag, tx_done_flag_reg, tx_buffer_empty_flag_reg};
  assign enables = {ctrl_reg.rx_irq_enable, ctrl_reg.tx_done_irq_enable, ctrl_reg.buffer_empty_irq_enable};
  assign irq_o = gie_reg & |(evt_reg & mask_reg & enables & live);

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership

  assign txd_o = tx_owner ? txd_reg : port_txd_i;
  assign txd_oe_o = tx_owner | port_txd_oe_i;
  assign rx_pin_owned_o = ctrl_reg.receiver_enable;
  assign xck_o = sck_reg;
  assign xck_oe_o = tx_owner & spi_mode;

endmodule

// ---- test/usm_spi_ctrl_assertions.sv ----
// Port-level checker for the serial control block in shift-clock master mode.
// Assumes it is bound into usm_spi_ctrl and sees only that module's ports.
`timescale 1ns/1ns
module usm_spi_ctrl_assertions
  import usm_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic irq_o,
  input wire logic rx_pin_owned_o,
  input wire logic port_txd_i,
  input wire logic txd_o,
  input wire logic txd_oe_o,
  input wire logic xck_o,
  input wire logic xck_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic wr;
  logic rd;
  logic gie_reg;
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && penable_i && !pwrite_i;
  // The global enable has no pin, so shadow it from bus writes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gie_reg <= 1'b0;
    end else if (wr && paddr_i == {IDX_GIE, 2'h0}) begin
      gie_reg <= pwdata_i[0];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  AST_IRQ_GIE: assert property (!gie_reg |-> !irq_o)
    else $error("interrupt while global enable is off");
  AST_TXD_PORT: assert property (!txd_oe_o |-> txd_o == port_txd_i)
    else $error("serial out not given back to port");
  AST_RX_OWN: assert property (wr && paddr_i == {IDX_CTRL, 2'h0} |=> rx_pin_owned_o == $past(pwdata_i[4]))
    else $error("receiver pin ownership wrong");
  AST_TXOE_ON: assert property (wr && paddr_i == {IDX_CTRL, 2'h0} && pwdata_i[3] |=> txd_oe_o)
    else $error("serial out not claimed");
  AST_CTRL_RSVD: assert property (rd && paddr_i == {IDX_CTRL, 2'h0} |-> prdata_o[2:0] == CTRL_RSVD_READ)
    else $error("enable register low bits wrong");
  AST_FMT_RSVD: assert property (rd && paddr_i == {IDX_FMT, 2'h0} |-> prdata_o[5:3] == 3'h0)
    else $error("format register middle bits wrong");
  AST_MODE_OFF: assert property (wr && paddr_i == {IDX_FMT, 2'h0} && pwdata_i[7:6] != 2'h3 ##1 1'b1 |-> !xck_oe_o)
    else $error("shift clock driven outside master mode");
  AST_XCK_OWNED: assert property ($changed(xck_o) |-> $past(txd_oe_o) && $past(xck_oe_o))
    else $error("shift clock moved while not owned");
endmodule
bind usm_spi_ctrl usm_spi_ctrl_assertions u_chk (.clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .irq_o, .rx_pin_owned_o, .port_txd_i, .txd_o, .txd_oe_o, .xck_o, .xck_oe_o);

// ---- test/usm_spi_ctrl_tb.sv ----
// Self-checking bench for the serial control block in shift-clock master mode.
// Assumes a zero-wait APB slave and a baud value of 3 (80 ns link period).
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module usm_spi_ctrl_tb
  import usm_pkg::*;
;
  localparam int H = 4;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_ack = 1'b0, port_txd = 1'b1, port_oe = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, v, prdata_o;
  logic cpol = 1'b0, cpha = 1'b0, lsb = 1'b0, err;
  logic pready_o, pslverr_o, irq_o, rx_own, txd_o, txd_oe_o, xck_o, xck_oe_o, miso;
  int fail_count = 0, num_checks = 0, nedge = 0;
  time t0, tl;
  always #5 clk_i = ~clk_i;
  usm_spi_ctrl dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .irq_o(irq_o), .irq_ack_i(irq_ack), .rxd_i(miso), .rx_pin_owned_o(rx_own), .port_txd_i(port_txd),
    .port_txd_oe_i(port_oe), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .xck_o(xck_o), .xck_oe_o(xck_oe_o));
  usm_spi_slave u_slv (.sck_i(xck_o), .mosi_i(txd_o), .cpol_i(cpol), .cpha_i(cpha), .lsb_i(lsb), .miso_o(miso));
  always @(xck_o) begin
    if (nedge == 0) t0 = $time;
    tl = $time;
    nedge++;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    v = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the write land before the caller looks at pins
    #1;
  endtask
  task automatic wait_done();
    do apb(1'b0, IDX_STATUS, 32'h0); while (v[STA_TXC] !== 1'b1);
  endtask
  task automatic final_report();
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK({txd_oe_o, xck_oe_o, rx_own, irq_o}, 4'h0)
    apb(1'b0, IDX_STATUS, 32'h0);
    `CHK(v[7:0], 8'h26)
    apb(1'b0, IDX_CTRL, 32'h0);
    `CHK(v[7:0], 8'h06)
    apb(1'b0, IDX_FMT, 32'h0);
    `CHK(v[7:0], 8'h06)
    apb(1'b0, 10'h0c3, 32'h0);
    `CHK(err, 1'b1)
  endtask
  task automatic t_modes();
    logic [7:0] tx;
    logic [7:0] rx;
    apb(1'b1, IDX_BAUD, 32'h3);
    apb(1'b1, IDX_CTRL, 32'h18);
    `CHK({txd_oe_o, rx_own}, 2'h3)
    for (int m = 0; m < 8; m++) begin
      {lsb, cpha, cpol} = m[2:0];
      tx = 8'hc5 ^ 8'(m);
      rx = 8'h3a ^ 8'(m << 4);
      apb(1'b1, IDX_FMT, {24'h0, 8'hc0 | 8'(m)});
      apb(1'b0, IDX_FMT, 32'h0);
      `CHK(v[7:0], 8'hc0 | 8'(m))
      `CHK(xck_o, cpol)
      u_slv.load(rx);
      nedge = 0;
      apb(1'b1, IDX_DATA, {24'h0, tx});
      wait_done();
      `CHK(nedge, 16)
      `CHK(xck_o, cpol)
      `CHK(u_slv.in_reg, tx)
      apb(1'b0, IDX_DATA, 32'h0);
      `CHK(v[7:0], rx)
      apb(1'b1, IDX_STATUS, 32'h40);
      u_slv.park();
    end
  endtask
  task automatic t_refuse();
    nedge = 0;
    for (int md = 0; md < 3; md++) begin
      apb(1'b1, IDX_FMT, {24'h0, 2'(md), 6'h07});
      apb(1'b0, IDX_FMT, 32'h0);
      `CHK(v[7:6], 2'(md))
      if (md == 0) apb(1'b1, IDX_DATA, 32'ha5);
    end
    repeat (40) @(posedge clk_i);
    `CHK(nedge, 0)
    apb(1'b1, IDX_FMT, 32'hc7);
    wait_done();
    `CHK(nedge, 16)
    apb(1'b1, IDX_STATUS, 32'h40);
    apb(1'b0, IDX_DATA, 32'h0);
  endtask
  task automatic t_b2b();
    u_slv.load(8'h81);
    nedge = 0;
    apb(1'b1, IDX_DATA, 32'h5b);
    apb(1'b1, IDX_DATA, 32'hd4);
    wait_done();
    `CHK(nedge, 32)
    `CHK(tl - t0, 31 * H * 10)
    apb(1'b1, IDX_STATUS, 32'h40);
    apb(1'b0, IDX_STATUS, 32'h0);
    `CHK(v[STA_TXC], 1'b0)
  endtask
  task automatic t_flush();
    `CHK(v[STA_RXC], 1'b1)
    apb(1'b1, IDX_CTRL, 32'h08);
    `CHK(rx_own, 1'b0)
    apb(1'b0, IDX_STATUS, 32'h0);
    `CHK(v[STA_RXC], 1'b0)
    apb(1'b1, IDX_CTRL, 32'h18);
  endtask
  task automatic t_irq();
    apb(1'b1, IDX_GIE, 32'h1);
    apb(1'b1, IDX_EVT, 32'h7);
    `CHK(irq_o, 1'b0)
    apb(1'b1, IDX_CTRL, 32'h58);
    apb(1'b1, IDX_DATA, 32'h24);
    wait_done();
    `CHK(irq_o, 1'b1)
    @(posedge clk_i);
    irq_ack <= 1'b1;
    @(posedge clk_i);
    irq_ack <= 1'b0;
    #1;
    `CHK(irq_o, 1'b0)
    apb(1'b1, IDX_CTRL, 32'h38);
    `CHK(irq_o, 1'b1)
    apb(1'b1, IDX_GIE, 32'h0);
    `CHK(irq_o, 1'b0)
    apb(1'b1, IDX_GIE, 32'h1);
    apb(1'b1, IDX_MASK, 32'h6);
    `CHK(irq_o, 1'b0)
    apb(1'b1, IDX_MASK, 32'h7);
    apb(1'b1, IDX_EVT, 32'h1);
    `CHK(irq_o, 1'b0)
    apb(1'b1, IDX_CTRL, 32'h18);
    apb(1'b0, IDX_DATA, 32'h0);
  endtask
  task automatic t_disable();
    nedge = 0;
    apb(1'b1, IDX_DATA, 32'h69);
    apb(1'b1, IDX_CTRL, 32'h00);
    `CHK(txd_oe_o, 1'b1)
    while (txd_oe_o !== 1'b0) @(posedge clk_i);
    #1;
    `CHK(nedge, 16)
    `CHK(txd_o, port_txd)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_modes();
    t_refuse();
    t_b2b();
    t_flush();
    t_irq();
    t_disable();
    final_report();
  end
  // Whole run is under two thousand cycles; this leaves wide margin
  initial begin
    #400000;
    fail_count++;
    final_report();
  end
endmodule

// ---- test/usm_spi_slave.sv ----
// Behavioural shift-clock slave on the far side of the serial pins.
// Assumes the bench sets the mode inputs and loads a reply byte before frames.
`timescale 1ns/1ns
module usm_spi_slave (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic lsb_i,
  output logic miso_o
);
  logic [7:0] out_reg = 8'h00;
  logic [7:0] in_reg = 8'h00;
  int n = 0;
  initial miso_o = 1'b0;
  function automatic logic nth(input int k);
    return lsb_i ? out_reg[k] : out_reg[7 - k];
  endfunction
  task automatic load(input logic [7:0] b);
    out_reg = b;
    n = 0;
    miso_o = nth(0);
  endtask
  // Released line shows the inverse, so a stale sample cannot pass
  task automatic park();
    miso_o = ~miso_o;
  endtask
  always @(sck_i) begin
    if ((sck_i != cpol_i) != cpha_i) begin
      in_reg = lsb_i ? {mosi_i, in_reg[7:1]} : {in_reg[6:0], mosi_i};
      n = (n + 1) % 8;
    end else begin
      miso_o = nth(n);
    end
  end
endmodule
